// [hw/stei_defs.svh]
// constants for the serial transmit escape interpreter
`ifndef STEI_DEFS_SVH
`define STEI_DEFS_SVH

// escape byte and control codes
`define STEI_ESC          8'h1b
`define STEI_CODE_BREAK   8'h11
`define STEI_CODE_NINTH   8'h12
`define STEI_CODE_PAUSE   8'h13
`define STEI_CODE_RTS     8'h14

// timing, each in its own unit
`define STEI_CLK_NS       10
`define STEI_BAUD         115200
`define STEI_BRK_UNIT_US  100
`define STEI_PAUSE_UNIT_MS 1

// frame lengths in bit times, start and stop included
`define STEI_FRAME_W      11
`define STEI_BITS_8       4'ha
`define STEI_BITS_9       4'hb

// reset values
`define STEI_RTS_RST      1'b0
`define STEI_NINTH_RST    1'b0

`endif

// [hw/stei_pkg.sv]
// types shared by the escape interpreter files
package stei_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ESC,
		ST_PARAM,
		ST_SEND,
		ST_BREAK,
		ST_PAUSE
	} stei_state_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} stei_stream_t;

endpackage

// [hw/stei_tick.sv]
// enable-pulse divider, restarted by a clear
`timescale 1ns/100ps
module stei_tick #(
	parameter int DIV = 868
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// control
	input  wire logic clr,
	// enable pulse
	output logic      tick
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

	logic [W-1:0] cnt_q;
	wire          at_end = (cnt_q == W'(DIV - 1));

	// first pulse lands in the DIV-th cycle after clear drops
	assign tick = !clr && at_end;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_q <= '0;
		else if (clr || at_end)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + W'(1);
	end
endmodule

// [hw/stei_top.sv]
// serial transmitter that executes in-band escape sequences
`timescale 1ns/100ps
`include "stei_defs.svh"
module stei_top import stei_pkg::*; #(
	parameter int P_BIT_CYC   = 1000000000 / (`STEI_CLK_NS * `STEI_BAUD),
	parameter int P_BRK_CYC   = `STEI_BRK_UNIT_US * 1000 / `STEI_CLK_NS,
	parameter int P_PAUSE_CYC = `STEI_PAUSE_UNIT_MS * 1000000 / `STEI_CLK_NS
) (
	// clock and reset
	input  wire logic   core_clk,
	input  wire logic   rstn,
	// outgoing character stream from the host
	input  stei_stream_t in_s,
	output logic         in_ready,
	// configuration
	input  wire logic   nine_bit_mode_on,
	// line side
	output logic         tx_out,
	output logic         rts_out
);
	stei_state_t state_q, state_d;
	logic [7:0]  code_q;
	logic [7:0]  remain_q;
	logic [7:0]  dur_q;
	logic        ninth_q;
	logic        rts_q;
	logic [`STEI_FRAME_W-1:0] shift_q;
	logic [3:0]  bits_q;
	logic        tx_q;
	logic        tx_d;
	logic        bit_tick, brk_tick, ms_tick;

	assign in_ready = (state_q == ST_IDLE) || (state_q == ST_ESC) || (state_q == ST_PARAM);

	wire       accept    = in_s.valid && in_ready;
	wire [7:0] prm       = in_s.data;
	wire       is_esc    = (in_s.data == `STEI_ESC);
	wire       load_char = accept && (state_q == ST_IDLE) && !is_esc;
	wire       seq_done  = accept && (state_q == ST_PARAM);
	wire       prm_bit   = (prm[7:1] == 7'h00);
	wire       do_brk    = seq_done && (code_q == `STEI_CODE_BREAK) && (prm != 8'h00);
	wire       do_pause  = seq_done && (code_q == `STEI_CODE_PAUSE) && (prm != 8'h00);
	wire       set_ninth = seq_done && (code_q == `STEI_CODE_NINTH) && prm_bit;
	wire       set_rts   = seq_done && (code_q == `STEI_CODE_RTS) && prm_bit;
	wire       wait_tick = (state_q == ST_BREAK) ? brk_tick : ms_tick;
	wire       time_up   = wait_tick && (remain_q == 8'h01);
	wire       last_bit  = bit_tick && (bits_q == 4'h1);

	// ninth bit only framed in nine-bit mode
	// no parity slot, single stop bit
	wire [`STEI_FRAME_W-1:0] frame = nine_bit_mode_on ?
		{1'b1, ninth_q, in_s.data, 1'b0} : {2'b11, in_s.data, 1'b0};
	wire [3:0] frame_bits = nine_bit_mode_on ? `STEI_BITS_9 : `STEI_BITS_8;

	// dividers restart on entry so every interval is whole
	stei_tick #(.DIV(P_BIT_CYC)) u_bit (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clr      (state_q != ST_SEND),
		.tick     (bit_tick)
	);
	stei_tick #(.DIV(P_BRK_CYC)) u_brk (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clr      (state_q != ST_BREAK),
		.tick     (brk_tick)
	);
	stei_tick #(.DIV(P_PAUSE_CYC)) u_ms (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clr      (state_q != ST_PAUSE),
		.tick     (ms_tick)
	);

	// escape bytes steer the state, never the shifter
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (accept)
					state_d = is_esc ? ST_ESC : ST_SEND;
			ST_ESC:
				if (accept)
					state_d = ST_PARAM;
			ST_PARAM:
				if (accept)
					state_d = do_brk ? ST_BREAK : (do_pause ? ST_PAUSE : ST_IDLE);
			ST_SEND:
				if (last_bit)
					state_d = ST_IDLE;
			// stays put until the last tick of the break
			ST_BREAK:
				if (time_up)
					state_d = ST_IDLE;
			ST_PAUSE:
				if (time_up)
					state_d = ST_IDLE;
		endcase
	end

	assign tx_d = (state_q == ST_SEND) ? shift_q[0] : (state_q != ST_BREAK);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ST_IDLE;
			tx_q    <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			tx_q    <= tx_d;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			code_q <= 8'h00;
		else if (accept && (state_q == ST_ESC))
			code_q <= in_s.data;
	end

	// break and pause share one countdown
	// loaded with the millisecond count too
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			remain_q <= 8'h00;
			dur_q    <= 8'h00;
		end
		else if (do_brk || do_pause)
		begin
			remain_q <= prm;
			dur_q    <= prm;
		end
		else if (((state_q == ST_BREAK) || (state_q == ST_PAUSE)) && wait_tick)
			remain_q <= remain_q - 8'h01;
	end

	// ninth bit kept for later characters
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			ninth_q <= `STEI_NINTH_RST;
		else if (set_ninth)
			ninth_q <= prm[0];
	end

	// parameter 0 drives high, 1 drives low
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rts_q <= `STEI_RTS_RST;
		else if (set_rts)
			rts_q <= !prm[0];
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			shift_q <= '1;
			bits_q  <= 4'h0;
		end
		else if (load_char)
		begin
			shift_q <= frame;
			bits_q  <= frame_bits;
		end
		else if ((state_q == ST_SEND) && bit_tick)
		begin
			shift_q <= {1'b1, shift_q[`STEI_FRAME_W-1:1]};
			bits_q  <= bits_q - 4'h1;
		end
	end

	assign tx_out  = tx_q;
	assign rts_out = rts_q;

	// cycles spent in the current state, for the timing checks
	logic [31:0] dwell_q;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			dwell_q <= 32'h0;
		else if (state_d != state_q)
			dwell_q <= 32'h0;
		else
			dwell_q <= dwell_q + 32'h1;
	end

	wire brk_exit   = (state_q == ST_BREAK) && (state_d != ST_BREAK);
	wire pause_exit = (state_q == ST_PAUSE) && (state_d != ST_PAUSE);

	a_esc_not_sent: assert property (@(posedge core_clk) disable iff (!rstn)
		(accept && (state_q == ST_IDLE) && is_esc) |=> (state_q == ST_ESC) ##0 tx_q [*2])
		else $error("escape byte reached the line");
	a_break_len: assert property (@(posedge core_clk) disable iff (!rstn)
		brk_exit |-> (dwell_q == 32'(int'(dur_q) * P_BRK_CYC - 1)))
		else $error("break length wrong");
	// host held off for the whole break, the line one cycle behind the state
	a_break_space: assert property (@(posedge core_clk) disable iff (!rstn)
		(state_q == ST_BREAK) |-> !in_ready ##1 !tx_q)
		else $error("line not spacing during break");
	a_ninth_zero: assert property (@(posedge core_clk) disable iff (!rstn)
		(load_char && nine_bit_mode_on && !ninth_q) |=> !shift_q[9] && shift_q[10])
		else $error("ninth bit not zero");
	a_ninth_one: assert property (@(posedge core_clk) disable iff (!rstn)
		(load_char && nine_bit_mode_on && ninth_q) |=> shift_q[9] && !shift_q[0])
		else $error("ninth bit not one");
	a_eight_bit_frame: assert property (@(posedge core_clk) disable iff (!rstn)
		(load_char && !nine_bit_mode_on) |=> shift_q[9] && (bits_q == 4'ha))
		else $error("ninth bit leaked into eight-bit frame");
	a_frame_len: assert property (@(posedge core_clk) disable iff (!rstn)
		(load_char && nine_bit_mode_on) |=> (bits_q == 4'hb) && !shift_q[0] && shift_q[10])
		else $error("nine-bit frame not start plus nine plus one stop");
	a_pause_len: assert property (@(posedge core_clk) disable iff (!rstn)
		pause_exit |-> (dwell_q == 32'(int'(dur_q) * P_PAUSE_CYC - 1)))
		else $error("pause length wrong");
	a_rts_high: assert property (@(posedge core_clk) disable iff (!rstn)
		(set_rts && !prm[0]) |=> rts_out)
		else $error("handshake not high");
	a_rts_low: assert property (@(posedge core_clk) disable iff (!rstn)
		(set_rts && prm[0]) |=> !rts_out)
		else $error("handshake not low");

	c_break: cover property (@(posedge core_clk) disable iff (!rstn) brk_exit);
	c_pause: cover property (@(posedge core_clk) disable iff (!rstn) pause_exit);
	c_nine_bit: cover property (@(posedge core_clk) disable iff (!rstn)
		load_char && nine_bit_mode_on && ninth_q);
	c_rts_set: cover property (@(posedge core_clk) disable iff (!rstn) set_rts);
endmodule

// [dv/stei_line_rx.sv]
// behavioural line receiver standing for the far-side equipment
`timescale 1ns/100ps
module stei_line_rx #(
	parameter int BIT = 4
) (
	// clock and line
	input  wire logic core_clk,
	input  wire logic line,
	input  wire logic nine,
	// what arrived
	output logic [7:0] rx_data,
	output logic       rx_ninth,
	output int         rx_cnt,
	output int         brk_cnt
);
	logic [8:0] sh;

	initial
	begin
		rx_cnt = 0;
		brk_cnt = 0;
		rx_data = 8'h00;
		rx_ninth = 1'b0;
		forever
		begin
			@(negedge line);
			// sample mid-bit, away from the launching edge
			repeat (BIT / 2) @(negedge core_clk);
			sh = 9'h000;
			for (int i = 0; i < (nine ? 9 : 8); i++)
			begin
				repeat (BIT) @(negedge core_clk);
				sh[i] = line;
			end
			repeat (BIT) @(negedge core_clk);
			if (line === 1'b1)
			begin
				rx_data = sh[7:0];
				rx_ninth = sh[8];
				rx_cnt++;
			end
			else
			begin
				// low stop means break, not a character
				brk_cnt++;
				wait (line === 1'b1);
			end
		end
	end
endmodule

// [dv/tb_top.sv]
// self-checking bench for the escape interpreter
`timescale 1ns/100ps
`include "stei_defs.svh"
module tb_top;
	import stei_pkg::*;
	logic         core_clk;
	logic         rstn;
	logic         nine_bit_mode_on;
	logic         in_ready;
	logic         tx_out;
	logic         rts_out;
	stei_stream_t in_s;
	logic [7:0]   rx_data;
	logic         rx_ninth;
	int           rx_cnt;
	int           brk_cnt;
	int           errors;
	int           checks_done;

	stei_top #(.P_BIT_CYC(4), .P_BRK_CYC(20), .P_PAUSE_CYC(50)) i_dut (
		.core_clk(core_clk), .rstn(rstn), .in_s(in_s), .in_ready(in_ready),
		.nine_bit_mode_on(nine_bit_mode_on), .tx_out(tx_out), .rts_out(rts_out));
	stei_line_rx #(.BIT(4)) i_rx (
		.core_clk(core_clk), .line(tx_out), .nine(nine_bit_mode_on),
		.rx_data(rx_data), .rx_ninth(rx_ninth), .rx_cnt(rx_cnt), .brk_cnt(brk_cnt));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic put(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge core_clk);
		in_s = '{1'b1, b};
		while (in_ready !== 1'b1 && n < 3000)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 3000)
			errors++;
		@(negedge core_clk);
		in_s.valid = 1'b0;
	endtask

	task automatic seq(input logic [7:0] c, input logic [7:0] p);
		put(`STEI_ESC);
		put(c);
		put(p);
	endtask

	task automatic rx_wait(input int n);
		int k;
		k = 0;
		while (rx_cnt != n && k < 2000)
		begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 2000)
			errors++;
		repeat (8) @(negedge core_clk);
	endtask

	task automatic sc_text();
		put(8'h5a);
		rx_wait(1);
		chk("rx data", 32'h5a, rx_data);
		seq(`STEI_CODE_RTS, 8'h00);
		repeat (2) @(negedge core_clk);
		chk("rts", 32'h1, rts_out);
		seq(`STEI_CODE_RTS, 8'h01);
		repeat (2) @(negedge core_clk);
		chk("rts", 32'h0, rts_out);
		put(8'hc3);
		rx_wait(2);
		chk("frames", 32'h2, rx_cnt);
		chk("rx data", 32'hc3, rx_data);
	endtask

	task automatic sc_ninth();
		nine_bit_mode_on = 1'b1;
		seq(`STEI_CODE_NINTH, 8'h01);
		put(8'ha5);
		rx_wait(3);
		chk("ninth", 32'h1, rx_ninth);
		chk("rx data", 32'ha5, rx_data);
		seq(`STEI_CODE_NINTH, 8'h00);
		put(8'h3c);
		rx_wait(4);
		chk("ninth", 32'h0, rx_ninth);
		nine_bit_mode_on = 1'b0;
		// a stray ninth bit would read as a low stop
		put(8'h96);
		rx_wait(5);
		chk("breaks", 32'h0, brk_cnt);
		chk("rx data", 32'h96, rx_data);
	endtask

	task automatic sc_break();
		int n;
		n = 0;
		seq(`STEI_CODE_BREAK, 8'h02);
		while (tx_out !== 1'b0 && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		while (tx_out === 1'b0 && n < 1000)
		begin
			n++;
			@(negedge core_clk);
		end
		chk("break len", 32'd40, n);
		put(8'he7);
		rx_wait(6);
		chk("breaks", 32'h1, brk_cnt);
		chk("rx data", 32'he7, rx_data);
	endtask

	task automatic sc_pause();
		int n;
		n = 0;
		seq(`STEI_CODE_PAUSE, 8'h03);
		while (in_ready !== 1'b1 && n < 1000)
		begin
			@(negedge core_clk);
			n++;
		end
		chk("pause ok", 32'h1, 32'(n >= 149 && n <= 151));
		seq(`STEI_CODE_BREAK, 8'h00);
		put(8'h81);
		rx_wait(7);
		chk("breaks", 32'h1, brk_cnt);
		chk("rx data", 32'h81, rx_data);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		errors++;
		wrap_up();
	end

	initial
	begin
		errors = 0;
		checks_done = 0;
		rstn = 1'b0;
		in_s = '0;
		nine_bit_mode_on = 1'b0;
		repeat (10) @(negedge core_clk);
		rstn = 1'b1;
		chk("idle line", 32'h1, tx_out);
		chk("rts", 32'h0, rts_out);
		chk("ready", 32'h1, in_ready);
		sc_text();
		sc_ninth();
		sc_break();
		sc_pause();
		wrap_up();
	end
endmodule
